// *** lcd_frame_blink_consts.vh ***
`ifndef LCD_FRAME_BLINK_CONSTS_VH
`define LCD_FRAME_BLINK_CONSTS_VH

// special function register addresses
`define SFR_BLINK_FRAME_CLOCK 8'h96
`define SFR_DRIVE_VOLTAGE 8'h9c
`define SFR_REFRESH_INVERSION 8'hb1

// register reset values
`define RESET_BYTE 8'h00

// drive voltage config fields
`define LADDER_SELECT_BIT 6
`define BIAS_TOP_BIT 5
`define BIAS_LOW_MSB 4
`define BIAS_FULL_SCALE 6'h1f

// refresh and inversion config fields
`define INVERT_ENABLE_BIT 6
`define UPDATE_FLAG_BIT 1
`define HOLD_MEMORY_BIT 0

// blink and frame clock fields
`define BLINK_SOURCE_MSB 7
`define BLINK_SOURCE_LSB 6
`define BLINK_RATE_MSB 5
`define BLINK_RATE_LSB 4
`define FRAME_DIV_MSB 3
`define FRAME_DIV_LSB 0

// blink source codes
`define BLINK_SW_OFF 2'h0
`define BLINK_SW_ON 2'h1
`define BLINK_FIXED 2'h2
`define BLINK_RATE 2'h3

// multiplex level codes
`define MUX_RESERVED 2'h0
`define MUX_2X 2'h1
`define MUX_3X 2'h2
`define MUX_4X 2'h3

// frame divider: code zero behaves as the slowest divider
`define FRAME_DIV_SLOWEST 6'h20
`define LCD_TICKS_2048 13'h0800
`define LCD_TICKS_128 13'h0080

`endif

// *** lcd_frame_blink_control.v ***
`timescale 1ns/10ps
`default_nettype none
`include "lcd_frame_blink_consts.vh"

module lcd_frame_blink_control (
   input wire ref_clk_in,               // 200 MHz system clock
   input wire nrst_in,                  // async reset, active low
   input wire [7:0] sfr_addr_in,        // special function register address
   input wire [7:0] sfr_wdata_in,       // write data
   input wire sfr_wr_in,                // write strobe, one cycle
   input wire sfr_rd_in,                // read strobe, one cycle
   input wire tick_2048_in,             // one-cycle pulse at 2048 Hz
   input wire tick_128_in,              // one-cycle pulse at 128 Hz
   input wire lcd_clock_select_in,      // 0: 2048 Hz, 1: 128 Hz
   input wire [1:0] multiplex_level_in, // 1: 2x, 2: 3x, 3: 4x
   input wire blink_enable_in,          // blink mode enable
   output reg [7:0] sfr_rdata_out,      // read data, valid after read
   output reg charge_pump_enable_out,   // internal pump running
   output reg ladder_enable_out,        // external resistor ladder used
   output reg [5:0] bias_level_out,     // drive level in ref/31 steps
   output reg [1:0] common_index_out,   // active common line
   output reg frame_start_out,          // pulse at each frame boundary
   output reg frame_invert_out,         // drive waveform inverted
   output reg fetch_enable_out,         // display data fetched for panel
   output reg display_blank_out,        // all segments blanked
   output reg com2_active_out,          // shared pin acts as common 2
   output reg com3_active_out           // shared pin acts as common 3
);

   reg [7:0] blink_frame_clock;
   reg [6:0] drive_voltage;
   reg invert_enable;
   reg hold_memory;
   reg update_flag;
   reg [7:0] step_count;
   reg [1:0] common_index;
   reg frame_parity;
   reg fetch_pending;
   reg [12:0] blink_count;
   reg blink_toggle_due;
   reg blink_blank_phase;
   reg next_frame_start;

   wire [1:0] blink_source;
   wire [1:0] blink_rate;
   wire [3:0] frame_div;
   wire lcd_tick;
   wire mux_2x;
   wire [1:0] last_common;
   wire [5:0] div_base;
   wire [7:0] step_period;
   wire [12:0] quarter_second;
   reg [12:0] blink_half;
   wire wr_refresh;
   wire hold_rise;
   wire frame_edge;

   assign blink_source =
      blink_frame_clock[`BLINK_SOURCE_MSB:`BLINK_SOURCE_LSB];
   assign blink_rate = blink_frame_clock[`BLINK_RATE_MSB:`BLINK_RATE_LSB];
   assign frame_div = blink_frame_clock[`FRAME_DIV_MSB:`FRAME_DIV_LSB];

   // clock source and common step period
   assign lcd_tick = lcd_clock_select_in ? tick_128_in : tick_2048_in;
   // reserved mux code is driven as 2x so the commons never stall
   assign mux_2x = (multiplex_level_in == `MUX_2X) ||
                   (multiplex_level_in == `MUX_RESERVED);
   assign last_common = mux_2x ? `MUX_2X : multiplex_level_in;
   assign div_base = (frame_div == 4'h0) ? `FRAME_DIV_SLOWEST :
                     {2'h0, frame_div} + 6'h01;
   // 2x steps every 4(N+1) ticks, 3x and 4x twice as fast
   assign step_period = mux_2x ? {div_base, 2'h0} :
                        {1'b0, div_base, 1'b0};

   // blink half periods, in lcd ticks, from a quarter second
   assign quarter_second = lcd_clock_select_in ?
      (`LCD_TICKS_128 >> 2) : (`LCD_TICKS_2048 >> 2);
   always @* begin
      blink_half = quarter_second;
      if (blink_source == `BLINK_RATE) begin
         case (blink_rate)
            2'h0: blink_half = quarter_second << 1;
            2'h1: blink_half = quarter_second << 2;
            2'h2: blink_half = (quarter_second << 2) +
                               (quarter_second << 1);
            2'h3: blink_half = quarter_second << 3;
            default: blink_half = quarter_second << 1;
         endcase
      end
   end

   assign wr_refresh = sfr_wr_in && (sfr_addr_in == `SFR_REFRESH_INVERSION);
   assign hold_rise = wr_refresh && sfr_wdata_in[`HOLD_MEMORY_BIT] &&
                      !hold_memory;
   assign frame_edge = lcd_tick && (step_count + 8'h01 >= step_period) &&
                       (common_index >= last_common);

   // register writes; reserved bits are not stored and read back as zero
   always @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         blink_frame_clock <= `RESET_BYTE;
         drive_voltage <= 7'h00;
         invert_enable <= 1'b0;
         hold_memory <= 1'b0;
      end else if (sfr_wr_in) begin
         if (sfr_addr_in == `SFR_BLINK_FRAME_CLOCK)
            blink_frame_clock <= sfr_wdata_in;
         if (sfr_addr_in == `SFR_DRIVE_VOLTAGE)
            drive_voltage <= sfr_wdata_in[`LADDER_SELECT_BIT:0];
         if (wr_refresh) begin
            invert_enable <= sfr_wdata_in[`INVERT_ENABLE_BIT];
            hold_memory <= sfr_wdata_in[`HOLD_MEMORY_BIT];
         end
      end
   end

   // read port; unmapped addresses answer zero
   always @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         sfr_rdata_out <= `RESET_BYTE;
      end else if (sfr_rd_in) begin
         case (sfr_addr_in)
            `SFR_BLINK_FRAME_CLOCK: sfr_rdata_out <= blink_frame_clock;
            `SFR_DRIVE_VOLTAGE: sfr_rdata_out <= {1'b0, drive_voltage};
            `SFR_REFRESH_INVERSION: sfr_rdata_out <=
               {1'b0, invert_enable, 4'h0, update_flag, hold_memory};
            default: sfr_rdata_out <= `RESET_BYTE;
         endcase
      end
   end

   // common stepping and frame boundary
   always @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         step_count <= 8'h00;
         common_index <= 2'h0;
         frame_parity <= 1'b0;
         next_frame_start <= 1'b0;
      end else begin
         next_frame_start <= frame_edge;
         if (lcd_tick) begin
            if (step_count + 8'h01 >= step_period) begin
               step_count <= 8'h00;
               if (common_index >= last_common) begin
                  common_index <= 2'h0;
                  frame_parity <= !frame_parity;
               end else begin
                  common_index <= common_index + 2'h1;
               end
            end else begin
               step_count <= step_count + 8'h01;
            end
         end
      end
   end

   // memory hold handshake; a flag set beats a clear in the same cycle
   always @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         fetch_pending <= 1'b0;
         update_flag <= 1'b0;
      end else begin
         if (hold_memory || hold_rise)
            fetch_pending <= 1'b1;
         else if (frame_edge)
            fetch_pending <= 1'b0;
         if (frame_edge && fetch_pending && !hold_memory)
            update_flag <= 1'b1;
         else if (hold_rise)
            update_flag <= 1'b0;
      end
   end

   // hardware blink; a blank toggle waits for a frame edge so no frame
   // is shown half blank
   always @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         blink_count <= 13'h0000;
         blink_toggle_due <= 1'b0;
         blink_blank_phase <= 1'b0;
      end else if (!blink_source[1]) begin
         blink_count <= 13'h0000;
         blink_toggle_due <= 1'b0;
         blink_blank_phase <= 1'b0;
      end else begin
         if (lcd_tick) begin
            if (blink_count + 13'h0001 >= blink_half) begin
               blink_count <= 13'h0000;
               blink_toggle_due <= 1'b1;
            end else begin
               blink_count <= blink_count + 13'h0001;
            end
         end
         if (frame_edge && blink_toggle_due) begin
            blink_toggle_due <= 1'b0;
            blink_blank_phase <= !blink_blank_phase;
         end
      end
   end

   // registered outputs
   always @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         charge_pump_enable_out <= 1'b1;
         ladder_enable_out <= 1'b0;
         bias_level_out <= 6'h00;
         common_index_out <= 2'h0;
         frame_start_out <= 1'b0;
         frame_invert_out <= 1'b0;
         fetch_enable_out <= 1'b1;
         display_blank_out <= 1'b0;
         com2_active_out <= 1'b0;
         com3_active_out <= 1'b0;
      end else begin
         charge_pump_enable_out <= !drive_voltage[`LADDER_SELECT_BIT];
         ladder_enable_out <= drive_voltage[`LADDER_SELECT_BIT];
         bias_level_out <= drive_voltage[`BIAS_TOP_BIT] ?
            (`BIAS_FULL_SCALE + {1'b0, drive_voltage[`BIAS_LOW_MSB:0]}) :
            {1'b0, drive_voltage[`BIAS_LOW_MSB:0]};
         common_index_out <= common_index;
         frame_start_out <= next_frame_start;
         frame_invert_out <= invert_enable && frame_parity;
         fetch_enable_out <= !fetch_pending;
         if (!blink_enable_in)
            display_blank_out <= 1'b0;
         else if (blink_source == `BLINK_SW_OFF)
            display_blank_out <= 1'b1;
         else if (blink_source == `BLINK_SW_ON)
            display_blank_out <= 1'b0;
         else
            display_blank_out <= blink_blank_phase;
         com2_active_out <= (multiplex_level_in == `MUX_3X) ||
                            (multiplex_level_in == `MUX_4X);
         com3_active_out <= (multiplex_level_in == `MUX_4X);
      end
   end

endmodule

`default_nettype wire

// *** lcd_fb_asserts.sv ***
`timescale 1ns/10ps
`default_nettype none
module lcd_fb_asserts (
   input wire logic ref_clk_in, // system clock
   input wire logic nrst_in, // async reset, active low
   input wire logic sfr_wr_in, // write strobe
   input wire logic sfr_rd_in, // read strobe
   input wire logic [7:0] sfr_addr_in, // register address
   input wire logic [7:0] sfr_wdata_in, // write data
   input wire logic [7:0] sfr_rdata_out, // read data
   input wire logic [1:0] multiplex_level_in, // mux code
   input wire logic [1:0] common_index_out, // active common
   input wire logic [5:0] bias_level_out, // drive level
   input wire logic charge_pump_enable_out, // pump running
   input wire logic ladder_enable_out, // ladder used
   input wire logic frame_start_out, // frame boundary pulse
   input wire logic fetch_enable_out, // display data fetched
   input wire logic com3_active_out // shared pin is common 3
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!nrst_in);
   wire wr_volt = sfr_wr_in && sfr_addr_in == 8'h9c;
   wire wr_hold = sfr_wr_in && sfr_addr_in == 8'hb1 && sfr_wdata_in[0];
   wire rd_none = sfr_rd_in && sfr_addr_in != 8'h96 &&
      sfr_addr_in != 8'h9c && sfr_addr_in != 8'hb1;
   // upper half adds a full 31 steps on top of the low five bits
   function automatic logic [5:0] bias_of(input logic [7:0] w);
      return w[5] ? 6'h1f + {1'b0, w[4:0]} : {1'b0, w[4:0]};
   endfunction
   a_pump_ladder:
      assert property (ladder_enable_out != charge_pump_enable_out)
      else $error("pump and ladder not exclusive");
   a_ladder_write:
      assert property (wr_volt |-> ##2 ladder_enable_out ==
      $past(sfr_wdata_in[6], 2)) else $error("ladder not from write");
   a_bias_write:
      assert property (wr_volt |-> ##2 bias_level_out ==
      bias_of($past(sfr_wdata_in, 2))) else $error("bias level wrong");
   a_com3_decode:
      assert property ($stable(multiplex_level_in)[*3] |->
      com3_active_out == (multiplex_level_in == 2'h3))
      else $error("common 3 decode wrong");
   a_frame_pulse:
      assert property (frame_start_out |=> !frame_start_out)
      else $error("frame start longer than one cycle");
   a_frame_common:
      assert property (frame_start_out |-> common_index_out == 2'h0)
      else $error("frame not started on common 0");
   a_hold_stops:
      assert property (wr_hold |-> ##2 !fetch_enable_out)
      else $error("fetch not stopped by hold");
   a_resume_edge:
      assert property ($rose(fetch_enable_out) |-> frame_start_out)
      else $error("fetch resumed off a frame edge");
   a_unmapped_read:
      assert property (rd_none |=> sfr_rdata_out == 8'h00)
      else $error("unmapped read not zero");
   cover property ($rose(fetch_enable_out));
   cover property (frame_start_out && com3_active_out);
   cover property ($rose(ladder_enable_out));
endmodule
bind lcd_frame_blink_control lcd_fb_asserts u_lcd_fb_asserts (
   .ref_clk_in(ref_clk_in),
   .nrst_in(nrst_in),
   .sfr_wr_in(sfr_wr_in),
   .sfr_rd_in(sfr_rd_in),
   .sfr_addr_in(sfr_addr_in),
   .sfr_wdata_in(sfr_wdata_in),
   .sfr_rdata_out(sfr_rdata_out),
   .multiplex_level_in(multiplex_level_in),
   .common_index_out(common_index_out),
   .bias_level_out(bias_level_out),
   .charge_pump_enable_out(charge_pump_enable_out),
   .ladder_enable_out(ladder_enable_out),
   .frame_start_out(frame_start_out),
   .fetch_enable_out(fetch_enable_out),
   .com3_active_out(com3_active_out)
);
`default_nettype wire

// *** lcd_panel_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module lcd_panel_model (
   input wire logic ref_clk_in, // system clock
   input wire logic nrst_in, // async reset, active low
   input wire logic frame_start_in, // frame boundary from driver
   output logic [15:0] frame_len_out // clocks between last two frames
);
   logic [15:0] run;
   // the panel only sees whole frames, so it times boundary to boundary
   always @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         run <= 16'h0000;
         frame_len_out <= 16'h0000;
      end else if (frame_start_in) begin
         frame_len_out <= run;
         run <= 16'h0001;
      end else begin
         run <= run + 16'h0001;
      end
   end
endmodule
`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic ref_clk_in = 0, nrst_in = 0, wr = 0, rd = 0, t2k = 0, t128 = 0;
   logic sel = 0, blink = 0;
   logic [1:0] mux = 2'h1, com;
   logic [3:0] fd;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
   logic [5:0] bias;
   logic [15:0] e, flen;
   logic pump, ladder, fst, finv, fetch, blank, com2, com3, p;
   int err_total = 0, tests_run = 0, cyc = 0, n, t0;
   logic [22:0] tbl [6] = '{{1'b0, 2'h1, 4'h1, 16'd32},
      {1'b0, 2'h2, 4'h1, 16'd24}, {1'b1, 2'h1, 4'h2, 16'd72},
      {1'b0, 2'h0, 4'h1, 16'd32}, {1'b0, 2'h3, 4'h3, 16'd64},
      {1'b0, 2'h3, 4'h0, 16'd512}};
   logic [7:0] hw [5] = '{8'h81, 8'hc1, 8'hd1, 8'he1, 8'hf1};
   int hh [5] = '{96, 192, 384, 576, 768};
   always #2.5 ref_clk_in = ~ref_clk_in;
   // lcd ticks sped up: 2048 Hz source every 2 clocks, 128 Hz every 3
   always @(negedge ref_clk_in) begin
      cyc <= cyc + 1;
      t2k <= (cyc % 2 == 0);
      t128 <= (cyc % 3 == 0);
      if (cyc > 40000) begin
         err_total++;
         final_report;
      end
   end
   lcd_frame_blink_control u_lcd_frame_blink_control (.ref_clk_in(ref_clk_in),
      .nrst_in(nrst_in), .sfr_addr_in(addr), .sfr_wdata_in(wdata),
      .sfr_wr_in(wr), .sfr_rd_in(rd), .tick_2048_in(t2k),
      .tick_128_in(t128), .lcd_clock_select_in(sel),
      .multiplex_level_in(mux), .blink_enable_in(blink),
      .sfr_rdata_out(rdata), .charge_pump_enable_out(pump),
      .ladder_enable_out(ladder), .bias_level_out(bias),
      .common_index_out(com), .frame_start_out(fst),
      .frame_invert_out(finv), .fetch_enable_out(fetch),
      .display_blank_out(blank), .com2_active_out(com2),
      .com3_active_out(com3));
   lcd_panel_model u_lcd_panel_model (.ref_clk_in(ref_clk_in),
      .nrst_in(nrst_in), .frame_start_in(fst), .frame_len_out(flen));
   task chk(input logic [15:0] seen, exp, input string what);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // one-cycle strobes, then let the decoded outputs settle
   task wr_reg(input logic [7:0] a, d);
      @(negedge ref_clk_in);
      addr = a;
      wdata = d;
      wr = 1;
      @(negedge ref_clk_in);
      wr = 0;
      repeat (2) @(negedge ref_clk_in);
   endtask
   task rd_reg(input logic [7:0] a, exp);
      @(negedge ref_clk_in);
      addr = a;
      rd = 1;
      @(negedge ref_clk_in);
      rd = 0;
      @(negedge ref_clk_in);
      chk(rdata, exp, "read");
   endtask
   task frames(input int k);
      repeat (k) @(posedge fst);
      repeat (2) @(negedge ref_clk_in);
   endtask
   task final_report;
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (5) @(negedge ref_clk_in);
      nrst_in = 1;
      chk({pump, ladder, fetch, blank}, 4'b1010, "reset");
      rd_reg(8'h96, 8'h00);
      rd_reg(8'h9c, 8'h00);
      wr_reg(8'h95, 8'hff);
      rd_reg(8'h95, 8'h00);
      wr_reg(8'h9c, 8'h40);
      chk({pump, ladder}, 2'b01, "ladder");
      wr_reg(8'h9c, 8'h25);
      chk({pump, ladder, bias}, {2'b10, 6'd36}, "bias");
      wr_reg(8'h9c, 8'h1f);
      chk(bias, 6'd31, "bias low");
      rd_reg(8'h9c, 8'h1f);
      // software keeps the reserved refresh bits at zero on every write
      wr_reg(8'hb1, 8'h40);
      rd_reg(8'hb1, 8'h40);
      // frame length in clocks for each mux code, dividers 0 to 3 and both clock picks
      for (n = 0; n < 6; n++) begin
         {sel, mux, fd, e} = tbl[n];
         wr_reg(8'h96, {4'h0, fd});
         frames(3);
         chk(flen, e, "frame");
         chk({com2, com3}, {mux[1], mux == 2'h3}, "coms");
      end
      // hold and update flag, with inversion on; frames are long here
      wr_reg(8'hb1, 8'h41);
      rd_reg(8'hb1, 8'h41);
      frames(2);
      chk(fetch, 1'b0, "held");
      wr_reg(8'hb1, 8'h40);
      rd_reg(8'hb1, 8'h40);
      frames(1);
      chk(fetch, 1'b1, "resume");
      rd_reg(8'hb1, 8'h42);
      p = finv;
      frames(1);
      chk(finv, !p, "invert");
      wr_reg(8'hb1, 8'h41);
      rd_reg(8'hb1, 8'h41);
      wr_reg(8'hb1, 8'h00);
      frames(1);
      chk(finv, 1'b0, "no invert");
      frames(1);
      chk(finv, 1'b0, "no invert");
      // blink on the slow clock keeps the periods short
      {sel, mux, blink} = 4'b1011;
      wr_reg(8'h96, 8'h01);
      frames(2);
      chk(blank, 1'b1, "sw off");
      wr_reg(8'h96, 8'h41);
      frames(2);
      chk(blank, 1'b0, "sw on");
      for (n = 0; n < 5; n++) begin
         wr_reg(8'h96, hw[n]);
         @(posedge blank);
         t0 = cyc;
         @(negedge blank);
         p = (cyc - t0 >= hh[n]) && (cyc - t0 <= hh[n] + 50);
         chk(p, 1'b1, "blink");
      end
      // turn blink off while blanked, so the check can see it clear
      @(posedge blank);
      @(negedge ref_clk_in);
      blink = 0;
      frames(2);
      chk(blank, 1'b0, "blink off");
      final_report;
   end
endmodule
`default_nettype wire
